//--- tcam_pkg.sv
/*
 package for the temperature channel alarm monitor: channel counts,
 register offsets, field positions, defaults, limits and timing.
 assumes a single 10 MHz system clock.
*/
`default_nettype none
package tcam_pkg;
   localparam int NUM_CH = 8;
   localparam int NUM_BRG = 6;
   localparam int TEMP_W = 8;
   localparam int CLK_HZ = 10_000_000;
   localparam int SEC_TICK_MS = 1000;
   localparam int SEC_TICK_CYCLES = CLK_HZ / 1000 * SEC_TICK_MS;
   localparam int TICKS_PER_MIN = 60;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DISPLAY = 8'h08;
   localparam logic [7:0] OFS_CH_BASE = 8'h10;
   // ctrl fields
   localparam int CTRL_UNIT_C = 0;
   localparam int CTRL_HOLD_LSB = 8;
   // channel word a fields
   localparam int CA_EN = 0;
   localparam int CA_RATE_EN = 1;
   localparam int CA_SRC_LSB = 2;
   localparam int CA_ABS_LSB = 8;
   localparam int CA_REL_LSB = 16;
   // channel word b fields
   localparam int CB_RATE_LSB = 0;
   localparam int CB_ADLY_LSB = 8;
   localparam int CB_SDLY_LSB = 16;
   // defaults and limits, fahrenheit then celsius
   localparam logic [7:0] ABS_DEF_F = 8'd140;
   localparam logic [7:0] ABS_DEF_C = 8'd60;
   localparam logic [7:0] ABS_MIN_F = 8'd32;
   localparam logic [7:0] ABS_MAX_F = 8'd230;
   localparam logic [7:0] ABS_MIN_C = 8'd1;
   localparam logic [7:0] ABS_MAX_C = 8'd110;
   localparam logic [7:0] REL_DEF_F = 8'd30;
   localparam logic [7:0] REL_DEF_C = 8'd15;
   localparam logic [7:0] REL_MIN_F = 8'd2;
   localparam logic [7:0] REL_MAX_F = 8'd90;
   localparam logic [7:0] REL_MIN_C = 8'd1;
   localparam logic [7:0] REL_MAX_C = 8'd50;
   localparam logic [5:0] RATE_DEF = 6'd30;
   localparam logic [5:0] RATE_MIN = 6'd20;
   localparam logic [5:0] RATE_MAX = 6'd50;
   localparam logic [3:0] ADLY_DEF = 4'd1;
   localparam logic [3:0] ADLY_MAX = 4'd10;
   localparam logic [5:0] SDLY_DEF = 6'd60;
   localparam logic [5:0] SDLY_MAX = 6'd60;
   localparam logic [7:0] EN_DEF = 8'h0f;
   localparam logic [3:0] SRC_OFF = 4'h0;
   localparam logic [7:0] HOLD_DEF = 8'h00;
   typedef enum logic [1:0] {TCAM_LOG_TRIP, TCAM_LOG_ALARM, TCAM_LOG_STOP} tcam_log_t;
endpackage
`default_nettype wire

//--- tcam_monitor.sv
/*
 temperature channel alarm monitor: six bearing and two ambient channels,
 absolute, relative and rise-rate checks, cumulative alarm and stop delays,
 relays, leds, warnings and alarm log events.
 assumes readings are synchronous to mclk, register strobes one cycle long.
*/
// The register offsets and the address-and-strobe port were decided locally.
`default_nettype none
module tcam_monitor import tcam_pkg::*; #(
   parameter int TICK_CYCLES = SEC_TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [NUM_CH*TEMP_W-1:0] temp_in,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [NUM_CH-1:0] indicator_red,
   output logic [NUM_CH-1:0] warn_alarm,
   output logic [NUM_CH-1:0] warn_stop,
   output logic alarm_relay_energized,
   output logic stop_relay_energized,
   output logic alarm_led_amber,
   output logic stop_led_red,
   output logic stop_count_show,
   output logic [5:0] stop_count_display,
   output logic log_valid,
   output logic [2:0] log_chan,
   output tcam_log_t log_kind
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
      clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [2:0] lowest(input logic [NUM_CH-1:0] v);
      lowest = 3'd0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest = 3'(i);
         end
      end
   endfunction

   // configuration
   logic unit_c_reg;
   logic [7:0] holdoff_reg;
   logic [NUM_CH-1:0] en_reg;
   logic [NUM_CH-1:0] rate_en_reg;
   logic [3:0] src_reg [NUM_CH];
   logic [7:0] abs_reg [NUM_CH];
   logic [7:0] rel_reg [NUM_CH];
   logic [5:0] rate_reg [NUM_CH];
   logic [3:0] adly_reg [NUM_CH];
   logic [5:0] sdly_reg [NUM_CH];

   // state
   logic [TW-1:0] tick_cnt_reg;
   logic tick;
   logic [5:0] min_cnt_reg;
   logic minute;
   logic [7:0] hold_cnt_reg;
   logic rise_armed;
   logic rise_seeded_reg;
   logic [7:0] snap_reg [NUM_CH];
   logic [NUM_CH-1:0] rise_flag_reg;
   logic [NUM_CH-1:0] trip;
   logic [3:0] acnt_reg [NUM_CH];
   logic [5:0] scnt_reg [NUM_CH];
   logic [NUM_CH-1:0] alarm_act;
   logic [NUM_CH-1:0] stop_act;
   logic [NUM_CH-1:0] trip_d_reg, alarm_d_reg, stop_d_reg;
   logic [NUM_CH-1:0] pend_trip_reg, pend_alarm_reg, pend_stop_reg;

   logic [7:0] temp [NUM_CH];
   logic [7:0] abs_def, rel_def;
   logic [2:0] wr_ch;
   logic [7:0] ch_ofs;
   logic wr_ch_a, wr_ch_b;
   logic [3:0] wr_src;

   assign abs_def = unit_c_reg ? ABS_DEF_C : ABS_DEF_F;
   assign rel_def = unit_c_reg ? REL_DEF_C : REL_DEF_F;
   assign ch_ofs = reg_addr - OFS_CH_BASE;
   assign wr_ch = ch_ofs[5:3];
   assign wr_ch_a = reg_wr && reg_addr >= OFS_CH_BASE && reg_addr < 8'h50 && reg_addr[2] == 1'b0;
   assign wr_ch_b = reg_wr && reg_addr >= OFS_CH_BASE && reg_addr < 8'h50 && reg_addr[2] == 1'b1;
   assign wr_src = reg_wdata[CA_SRC_LSB +: 4];

   // global controls
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         unit_c_reg <= 1'b0;
         holdoff_reg <= HOLD_DEF;
      end else if (reg_wr && reg_addr == OFS_CTRL) begin
         unit_c_reg <= reg_wdata[CTRL_UNIT_C];
         holdoff_reg <= reg_wdata[CTRL_HOLD_LSB +: 8];
      end
   end

   // per-channel configuration; ranges clamped on write
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         en_reg <= EN_DEF;
         rate_en_reg <= '1;
         for (int i = 0; i < NUM_CH; i++) begin
            src_reg[i] <= SRC_OFF;
            abs_reg[i] <= ABS_DEF_F;
            rel_reg[i] <= REL_DEF_F;
            rate_reg[i] <= RATE_DEF;
            adly_reg[i] <= ADLY_DEF;
            sdly_reg[i] <= SDLY_DEF;
         end
      end else begin
         if (wr_ch_a) begin
            en_reg[wr_ch] <= reg_wdata[CA_EN];
            rate_en_reg[wr_ch] <= reg_wdata[CA_RATE_EN];
            abs_reg[wr_ch] <= unit_c_reg ?
               clamp8(reg_wdata[CA_ABS_LSB +: 8], ABS_MIN_C, ABS_MAX_C) :
               clamp8(reg_wdata[CA_ABS_LSB +: 8], ABS_MIN_F, ABS_MAX_F);
            rel_reg[wr_ch] <= unit_c_reg ?
               clamp8(reg_wdata[CA_REL_LSB +: 8], REL_MIN_C, REL_MAX_C) :
               clamp8(reg_wdata[CA_REL_LSB +: 8], REL_MIN_F, REL_MAX_F);
            // only bearings take a source, never themselves; codes 1..8 name channel 0..7
            if (wr_ch < 3'(NUM_BRG) && wr_src <= 4'(NUM_CH) && wr_src != 4'(wr_ch) + 4'h1) begin
               src_reg[wr_ch] <= wr_src;
            end else begin
               src_reg[wr_ch] <= SRC_OFF;
            end
            // auto-enable the chosen source with default settings
            if (wr_ch < 3'(NUM_BRG) && wr_src != SRC_OFF && wr_src <= 4'(NUM_CH) &&
                wr_src != 4'(wr_ch) + 4'h1 && !en_reg[3'(wr_src - 4'h1)]) begin
               en_reg[3'(wr_src - 4'h1)] <= 1'b1;
               rate_en_reg[3'(wr_src - 4'h1)] <= 1'b1;
               src_reg[3'(wr_src - 4'h1)] <= SRC_OFF;
               abs_reg[3'(wr_src - 4'h1)] <= abs_def;
               rel_reg[3'(wr_src - 4'h1)] <= rel_def;
               rate_reg[3'(wr_src - 4'h1)] <= RATE_DEF;
               adly_reg[3'(wr_src - 4'h1)] <= ADLY_DEF;
               sdly_reg[3'(wr_src - 4'h1)] <= SDLY_DEF;
            end
         end
         if (wr_ch_b) begin
            rate_reg[wr_ch] <= 6'(clamp8({2'b00, reg_wdata[CB_RATE_LSB +: 6]},
                                         {2'b00, RATE_MIN}, {2'b00, RATE_MAX}));
            adly_reg[wr_ch] <= 4'(clamp8({4'h0, reg_wdata[CB_ADLY_LSB +: 4]},
                                         8'h00, {4'h0, ADLY_MAX}));
            sdly_reg[wr_ch] <= 6'(clamp8({2'b00, reg_wdata[CB_SDLY_LSB +: 6]},
                                         8'h00, {2'b00, SDLY_MAX}));
         end
      end
   end

   // one-second tick and one-minute mark
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_reg <= '0;
      end else if (tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
   end
   assign tick = tick_cnt_reg == TW'(TICK_CYCLES - 1);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         min_cnt_reg <= '0;
      end else if (tick) begin
         min_cnt_reg <= minute ? 6'h00 : min_cnt_reg + 6'h01;
      end
   end
   assign minute = tick && min_cnt_reg == 6'(TICKS_PER_MIN - 1);

   // startup holdoff in seconds
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hold_cnt_reg <= '0;
      end else if (tick && !rise_armed) begin
         hold_cnt_reg <= hold_cnt_reg + 8'h01;
      end
   end
   assign rise_armed = hold_cnt_reg >= holdoff_reg;

   // first minute mark once armed only seeds the snapshots
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rise_seeded_reg <= 1'b0;
      end else if (!rise_armed) begin
         rise_seeded_reg <= 1'b0;
      end else if (minute) begin
         rise_seeded_reg <= 1'b1;
      end
   end

   // rise rate per minute, judged each minute mark and held until next
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         logic [7:0] rise;
         logic [7:0] src_t;
         logic rel_hit;
         assign temp[c] = temp_in[c*TEMP_W +: TEMP_W];
         assign rise = temp[c] > snap_reg[c] ? temp[c] - snap_reg[c] : 8'h00;
         assign src_t = src_reg[c] == SRC_OFF ? 8'h00 : temp[3'(src_reg[c] - 4'h1)];
         assign rel_hit = src_reg[c] != SRC_OFF &&
                          {1'b0, temp[c]} > {1'b0, src_t} + {1'b0, rel_reg[c]};

         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               snap_reg[c] <= '0;
               rise_flag_reg[c] <= 1'b0;
            end else if (minute) begin
               snap_reg[c] <= temp[c];
               // first minute after holdoff only seeds the snapshot
               rise_flag_reg[c] <= rate_en_reg[c] && rise_armed && rise_seeded_reg &&
                                   {4'h0, rise} * 12'd10 > {6'h00, rate_reg[c]};
            end else if (!rate_en_reg[c] || !rise_armed) begin
               rise_flag_reg[c] <= 1'b0;
            end
         end

         assign trip[c] = en_reg[c] && (temp[c] > abs_reg[c] || rel_hit ||
                                        rise_flag_reg[c]);

         // cumulative delay counters
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               acnt_reg[c] <= ADLY_DEF;
               scnt_reg[c] <= SDLY_DEF;
            end else if (trip[c]) begin
               if (tick && acnt_reg[c] != 4'h0) begin
                  acnt_reg[c] <= acnt_reg[c] - 4'h1;
               end
               if (tick && scnt_reg[c] != 6'h00) begin
                  scnt_reg[c] <= scnt_reg[c] - 6'h01;
               end
            end else begin
               if (acnt_reg[c] > adly_reg[c]) begin
                  acnt_reg[c] <= adly_reg[c];
               end else if (tick && acnt_reg[c] < adly_reg[c]) begin
                  acnt_reg[c] <= acnt_reg[c] + 4'h1;
               end
               if (scnt_reg[c] > sdly_reg[c]) begin
                  scnt_reg[c] <= sdly_reg[c];
               end else if (tick && scnt_reg[c] < sdly_reg[c]) begin
                  scnt_reg[c] <= scnt_reg[c] + 6'h01;
               end
            end
         end
         assign alarm_act[c] = trip[c] && acnt_reg[c] == 4'h0;
         assign stop_act[c] = trip[c] && scnt_reg[c] == 6'h00;
      end
   endgenerate

   // indicators, relays, leds, display
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         indicator_red <= '0;
         warn_alarm <= '0;
         warn_stop <= '0;
         alarm_relay_energized <= 1'b1;
         stop_relay_energized <= 1'b1;
         alarm_led_amber <= 1'b0;
         stop_led_red <= 1'b0;
         stop_count_show <= 1'b0;
         stop_count_display <= '0;
      end else begin
         indicator_red <= trip;
         warn_alarm <= alarm_act;
         warn_stop <= stop_act;
         alarm_relay_energized <= ~|alarm_act;
         stop_relay_energized <= ~|stop_act;
         alarm_led_amber <= |alarm_act;
         stop_led_red <= |stop_act;
         stop_count_show <= |alarm_act;
         stop_count_display <= |alarm_act ? scnt_reg[lowest(alarm_act)] : 6'h00;
      end
   end

   // alarm log: rising edges queue as pending, trips then alarms then stops, lowest channel first in each
   logic [NUM_CH-1:0] clr_trip, clr_alarm, clr_stop;
   always_comb begin
      clr_trip = '0;
      clr_alarm = '0;
      clr_stop = '0;
      if (|pend_trip_reg) begin
         clr_trip[lowest(pend_trip_reg)] = 1'b1;
      end else if (|pend_alarm_reg) begin
         clr_alarm[lowest(pend_alarm_reg)] = 1'b1;
      end else if (|pend_stop_reg) begin
         clr_stop[lowest(pend_stop_reg)] = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         trip_d_reg <= '0;
         alarm_d_reg <= '0;
         stop_d_reg <= '0;
         pend_trip_reg <= '0;
         pend_alarm_reg <= '0;
         pend_stop_reg <= '0;
      end else begin
         trip_d_reg <= trip;
         alarm_d_reg <= alarm_act;
         stop_d_reg <= stop_act;
         // a new edge wins over the clear of its own bit
         pend_trip_reg <= (pend_trip_reg & ~clr_trip) | (trip & ~trip_d_reg);
         pend_alarm_reg <= (pend_alarm_reg & ~clr_alarm) | (alarm_act & ~alarm_d_reg);
         pend_stop_reg <= (pend_stop_reg & ~clr_stop) | (stop_act & ~stop_d_reg);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         log_valid <= 1'b0;
         log_chan <= '0;
         log_kind <= TCAM_LOG_TRIP;
      end else begin
         log_valid <= |{clr_trip, clr_alarm, clr_stop};
         log_chan <= lowest(clr_trip | clr_alarm | clr_stop);
         log_kind <= |clr_trip ? TCAM_LOG_TRIP : (|clr_alarm ? TCAM_LOG_ALARM : TCAM_LOG_STOP);
      end
   end

   // register read, data in the following cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         if (reg_addr == OFS_CTRL) begin
            reg_rdata <= {16'h0000, holdoff_reg, 7'h00, unit_c_reg};
         end else if (reg_addr == OFS_STATUS) begin
            reg_rdata <= {6'h00, alarm_relay_energized, stop_relay_energized,
                          stop_act, alarm_act, trip};
         end else if (reg_addr == OFS_DISPLAY) begin
            reg_rdata <= {25'h0, stop_count_show, stop_count_display};
         end else if (reg_addr >= OFS_CH_BASE && reg_addr < 8'h50 && reg_addr[1:0] == 2'b00) begin
            reg_rdata <= reg_addr[2] ?
               {10'h000, sdly_reg[wr_ch], 4'h0, adly_reg[wr_ch], 2'b00, rate_reg[wr_ch]} :
               {8'h00, rel_reg[wr_ch], abs_reg[wr_ch], 2'b00, src_reg[wr_ch],
                rate_en_reg[wr_ch], en_reg[wr_ch]};
         end
      end
   end

   // checks
   a_relay_after_reset: assert property (@(posedge mclk) $rose(rst_b) |->
      alarm_relay_energized && stop_relay_energized) else $error("relay not energized");
   a_alarm_drops_relay: assert property (@(posedge mclk) disable iff (!rst_b)
      |alarm_act |=> !alarm_relay_energized && alarm_led_amber) else $error("alarm relay");
   a_stop_drops_relay: assert property (@(posedge mclk) disable iff (!rst_b)
      |stop_act |=> !stop_relay_energized && stop_led_red) else $error("stop relay");
   a_abs_trip_red: assert property (@(posedge mclk) disable iff (!rst_b)
      en_reg[0] && temp[0] > abs_reg[0] |=> indicator_red[0]) else $error("abs trip");
   a_disabled_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
      !en_reg[1] |-> !trip[1]) else $error("disabled channel tripped");
   a_rise_off_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
      !rate_en_reg[2] |=> !rise_flag_reg[2]) else $error("rise flag while off");
   a_holdoff_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
      !rise_armed |=> rise_flag_reg == '0) else $error("rise during holdoff");
   a_acnt_counts_down: assert property (@(posedge mclk) disable iff (!rst_b)
      trip[0] && tick && acnt_reg[0] != 4'h0 |=> acnt_reg[0] == $past(acnt_reg[0]) - 4'h1)
      else $error("alarm counter not stepping");
   a_scnt_recovers: assert property (@(posedge mclk) disable iff (!rst_b)
      !trip[0] && tick && scnt_reg[0] < sdly_reg[0] |=> scnt_reg[0] == $past(scnt_reg[0]) + 6'h01)
      else $error("stop counter not recovering");
   a_display_shown: assert property (@(posedge mclk) disable iff (!rst_b)
      |alarm_act |=> stop_count_show) else $error("stop count hidden");
   a_alarm_logged: assert property (@(posedge mclk) disable iff (!rst_b)
      alarm_act[0] && !alarm_d_reg[0] |=> pend_alarm_reg[0] || log_valid)
      else $error("alarm not queued");
endmodule
`default_nettype wire

//--- tcam_sensor_model.sv
/*
 thermistor sensor model: eight channel readings held as steady levels.
 assumes the bench sets one channel per strobe, synchronous to mclk.
*/
`default_nettype none
module tcam_sensor_model import tcam_pkg::*; (
   input wire logic mclk,
   input wire logic set_stb,
   input wire logic [2:0] set_ch,
   input wire logic [TEMP_W-1:0] set_val,
   output logic [NUM_CH*TEMP_W-1:0] temp_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // all sensors start at a plain room reading
   initial temp_in = {NUM_CH{8'h46}};
   always @(posedge mclk) begin
      if (set_stb) begin
         temp_in[set_ch*TEMP_W +: TEMP_W] <= set_val;
      end
   end
endmodule
`default_nettype wire

//--- tcam_testbench.sv
/*
 testbench for the temperature channel alarm monitor: defaults, clamps,
 absolute and relative trips, delays, relays and log entries.
 assumes the sensor model and a one-second tick shortened to ten cycles.
*/
`default_nettype none
module testbench import tcam_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TICK = 10;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic set_stb = 1'b0;
   logic [2:0] set_ch = 3'h0;
   logic [7:0] set_val = 8'h00;
   wire logic [63:0] temp_in;
   logic [31:0] reg_rdata;
   logic [7:0] indicator_red, warn_alarm, warn_stop;
   logic alarm_relay_energized, stop_relay_energized, alarm_led_amber, stop_led_red;
   logic stop_count_show, log_valid;
   logic [5:0] stop_count_display;
   logic [2:0] log_chan;
   tcam_log_t log_kind;
   logic [7:0] seen_trip = 8'h00, seen_alarm = 8'h00, seen_stop = 8'h00;
   int mismatches = 0, n_tests = 0, cycles = 0;

   tcam_sensor_model sensors_u (.mclk(mclk), .set_stb(set_stb), .set_ch(set_ch),
      .set_val(set_val), .temp_in(temp_in));
   tcam_monitor #(.TICK_CYCLES(TICK)) dut_u (.mclk(mclk), .rst_b(rst_b),
      .temp_in(temp_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .indicator_red(indicator_red),
      .warn_alarm(warn_alarm), .warn_stop(warn_stop),
      .alarm_relay_energized(alarm_relay_energized),
      .stop_relay_energized(stop_relay_energized), .alarm_led_amber(alarm_led_amber),
      .stop_led_red(stop_led_red), .stop_count_show(stop_count_show),
      .stop_count_display(stop_count_display), .log_valid(log_valid),
      .log_chan(log_chan), .log_kind(log_kind));

   initial forever #50 mclk = ~mclk;

   // hang guard and log capture
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         give_verdict();
      end
      if (log_valid === 1'b1) begin
         case (log_kind)
            TCAM_LOG_TRIP: seen_trip[log_chan] <= 1'b1;
            TCAM_LOG_ALARM: seen_alarm[log_chan] <= 1'b1;
            default: seen_stop[log_chan] <= 1'b1;
         endcase
      end
   end

   task automatic give_verdict();
      if (mismatches == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(what, reg_rdata, exp);
   endtask

   // one reading change, then three edges for the trip to show
   task automatic set_temp(input logic [2:0] c, input logic [7:0] v);
      @(posedge mclk);
      set_ch <= c;
      set_val <= v;
      set_stb <= 1'b1;
      @(posedge mclk);
      set_stb <= 1'b0;
      wait_cyc(3);
   endtask

   task automatic test_defaults();
      logic [7:0] a;
      chk("relays", {30'h0, alarm_relay_energized, stop_relay_energized}, 32'h3);
      chk("flags", {8'h0, indicator_red, warn_alarm, warn_stop}, 32'h0);
      for (int c = 0; c < NUM_CH; c++) begin
         a = OFS_CH_BASE + 8'(8 * c);
         rd_chk(a, {8'h00, REL_DEF_F, ABS_DEF_F, 2'b00, SRC_OFF, 1'b1, EN_DEF[c]},
            "word a");
         rd_chk(a + 8'h04, {10'h0, SDLY_DEF, 4'h0, ADLY_DEF, 2'b00, RATE_DEF},
            "word b");
      end
      rd_chk(OFS_CTRL, 32'h0, "ctrl");
      rd_chk(OFS_STATUS, 32'h0300_0000, "status");
      rd_chk(8'h0c, 32'h0, "unmapped");
   endtask

   task automatic test_clamps();
      wr(8'h18, {8'h00, 8'h01, 8'hfa, 8'h03});
      rd_chk(8'h18, {8'h00, REL_MIN_F, ABS_MAX_F, 8'h03}, "clamp f");
      wr(8'h1c, {10'h0, 6'h3f, 4'h0, 4'hf, 2'b00, 6'h3f});
      rd_chk(8'h1c, {10'h0, SDLY_MAX, 4'h0, ADLY_MAX, 2'b00, RATE_MAX}, "clamp b");
      wr(OFS_CTRL, 32'h1);
      wr(8'h18, {8'h00, 8'h5a, 8'hc8, 8'h03});
      rd_chk(8'h18, {8'h00, REL_MAX_C, ABS_MAX_C, 8'h03}, "clamp c");
      wr(OFS_CTRL, 32'h0);
      wr(8'h18, {8'h00, REL_DEF_F, ABS_DEF_F, 8'h03});
      wr(8'h1c, {10'h0, SDLY_DEF, 4'h0, ADLY_DEF, 2'b00, RATE_DEF});
   endtask

   task automatic test_absolute();
      set_temp(3'h0, ABS_DEF_F);
      chk("trip at limit", {24'h0, indicator_red}, 32'h0);
      set_temp(3'h0, ABS_DEF_F + 8'h01);
      chk("trip above", {24'h0, indicator_red}, 32'h1);
      wait_cyc(2 * TICK);
      chk("alarm", {24'h0, warn_alarm}, 32'h1);
      chk("alarm outs", {28'h0, alarm_relay_energized, alarm_led_amber,
         stop_relay_energized, stop_count_show}, 32'h7);
      chk("log a", {30'h0, seen_trip[0], seen_alarm[0]}, 32'h3);
      wait_cyc(527);
      chk("count", {31'h0, stop_count_display >= 6'h04 && stop_count_display <= 6'h07},
         32'h1);
      chk("no stop", {24'h0, warn_stop}, 32'h0);
      wait_cyc(8 * TICK);
      chk("stop", {22'h0, warn_stop, stop_relay_energized, stop_led_red}, 32'h005);
      chk("log s", {31'h0, seen_stop[0]}, 32'h1);
      set_temp(3'h0, 8'h46);
      chk("clear", {6'h0, indicator_red, warn_alarm, warn_stop, alarm_relay_energized,
         stop_relay_energized}, 32'h3);
      // short clear: stop counter only partly recovered
      wait_cyc(5 * TICK);
      set_temp(3'h0, 8'hc8);
      wait_cyc(2 * TICK);
      chk("retrip", {16'h0, warn_alarm, warn_stop}, 32'h100);
      wait_cyc(8 * TICK);
      chk("early stop", {24'h0, warn_stop}, 32'h1);
      set_temp(3'h0, 8'h46);
   endtask

   task automatic test_relative();
      logic [3:0] code [3] = '{4'h7, 4'h6, 4'h5};
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CH_BASE + 8'(16 + 8 * i), {8'h00, REL_DEF_F, ABS_DEF_F, 2'b00, code[i], 2'b01});
      end
      rd_chk(8'h40, {8'h00, REL_DEF_F, ABS_DEF_F, 2'b00, SRC_OFF, 2'b11}, "amb src");
      rd_chk(8'h38, {8'h00, REL_DEF_F, ABS_DEF_F, 2'b00, SRC_OFF, 2'b11}, "brg src");
      rd_chk(8'h30, {8'h00, REL_DEF_F, ABS_DEF_F, 2'b00, SRC_OFF, 2'b01}, "self src");
      set_temp(3'h2, 8'h64);
      chk("rel at limit", {24'h0, indicator_red}, 32'h0);
      set_temp(3'h2, 8'h65);
      chk("rel above", {24'h0, indicator_red}, 32'h4);
      set_temp(3'h6, 8'h50);
      chk("source rose", {24'h0, indicator_red}, 32'h0);
   endtask

   // five degrees inside one minute against a three degree limit
   task automatic test_rise();
      logic hit;
      logic drop;
      hit = 1'b0;
      drop = 1'b0;
      set_temp(3'h1, 8'h4b);
      repeat (61 * TICK) begin
         wait_cyc(1);
         hit = hit | (indicator_red[1] === 1'b1);
         drop = drop | (alarm_relay_energized === 1'b0);
      end
      chk("rise trip", {30'h0, hit, drop}, 32'h3);
      wait_cyc(61 * TICK);
      chk("rise gone", {30'h0, indicator_red[1], alarm_relay_energized}, 32'h1);
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      wait_cyc(1);
      test_defaults();
      test_clamps();
      test_absolute();
      test_relative();
      test_rise();
      give_verdict();
   end
endmodule
`default_nettype wire
